// [rtl/irhc_core.sv]
// Digital input routing matrix and home-switch position capture
// What this block does
// - Thirty-six 8-bit selectors; selector n drives routed bit n-1.
// - Code 0 gives constant 0; codes 1..16 pass physical input 1..16.
// - Code 128 gives constant 1.
// - Codes 129..144 give inverted physical input 1..16.
// - Selectors are read/write and reset to 0, so with routing enabled routed bits read 0.
// - Entry counts read as constants 24h (routing) and 04h (capture).
// - When enabled, home input level changes latch the encoder position.
// - Control 0 off, 1 rising, 2 falling, 3 both edges; resets to 0.
// - Counter counts captures, cleared when control written with 1..3.
// - Each capture stores the user-unit position.
// - Each capture also stores the raw 32-bit sensor position.
// - Selectors apply only while routing enable is 1.
// - Special-function enable bit 2 marks the home switch input.
module irhc_core
    import irhc_pkg::*;
#(
    parameter int N_ROUTE = IRHC_N_ROUTE
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [IRHC_N_PHYS-1:0] phys_in,
    input wire logic routing_en,
    input wire logic [31:0] special_fn_en,
    input wire logic [31:0] user_pos,
    input wire logic [31:0] sensor_pos,
    input wire irhc_od_req_t od_req,
    output irhc_od_rsp_t od_rsp,
    output logic [N_ROUTE-1:0] routed_input_word
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic irhc_route_bit(input logic [7:0] sel,
                                            input logic [IRHC_N_PHYS-1:0] p);
        logic [6:0] low;
        logic [3:0] k;
        low = sel[6:0];
        k = sel[3:0] - IRHC_SEL_BIAS;
        if (sel == IRHC_SEL_ONE)
            return 1'b1;
        else if (low >= IRHC_SEL_LO && low <= IRHC_SEL_HI)
            return p[k] ^ sel[IRHC_SEL_INV_BIT];
        else
            return 1'b0;
    endfunction

    function automatic logic irhc_hit(input irhc_od_req_t r,
                                      input logic [15:0] idx,
                                      input logic [7:0] sub);
        return r.index == idx && r.sub == sub;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] sel_reg [N_ROUTE];
    logic [IRHC_N_PHYS-1:0] sync1_reg, sync2_reg, prev_reg;
    irhc_mode_t mode_reg;
    logic [31:0] evcnt_reg, upos_reg, spos_reg;

    // ------------------------------------------------------------
    // Synchroniser and edge detection
    // ------------------------------------------------------------
    // No reset here: the chain tracks the pins through reset, so a home
    // pin that is high at release gives no false rising edge
    always_ff @(posedge mclk) begin
        sync1_reg <= phys_in;
        sync2_reg <= sync1_reg;
        prev_reg <= sync2_reg;
    end

    wire home_now = sync2_reg[IRHC_HOME_BIT];
    wire home_old = prev_reg[IRHC_HOME_BIT];
    wire rise = home_now & ~home_old;
    wire fall = ~home_now & home_old;
    // Home capture is gated by its special-function bit as well as the mode
    wire home_ena = special_fn_en[IRHC_HOME_BIT];
    wire want_rise = mode_reg == IRHC_RISE || mode_reg == IRHC_BOTH;
    wire want_fall = mode_reg == IRHC_FALL || mode_reg == IRHC_BOTH;
    wire capture = home_ena
                   & ((want_rise & rise) | (want_fall & fall));

    // ------------------------------------------------------------
    // Object-dictionary decode
    // ------------------------------------------------------------
    wire is_route = od_req.index == IRHC_IDX_ROUTE;
    wire [7:0] sel_idx = od_req.sub - IRHC_SUB_FIRST;
    wire sel_hit = is_route && od_req.sub >= IRHC_SUB_FIRST
                   && od_req.sub <= IRHC_ROUTE_CNT;
    wire ctrl_hit = irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_CTRL);
    wire ctrl_ok = od_req.wdata <= IRHC_CTRL_MAX;
    wire ctrl_wr = od_req.wr && ctrl_hit && ctrl_ok;
    wire ctrl_clear = ctrl_wr && od_req.wdata != IRHC_W32_RST;
    wire cnt_wr = od_req.wr && irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_EVCNT);
    wire upos_wr = od_req.wr && irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_UPOS);
    wire spos_wr = od_req.wr && irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_SPOS);
    wire route_cnt_hit = irhc_hit(od_req, IRHC_IDX_ROUTE, IRHC_SUB_COUNT);
    wire capt_cnt_hit = irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_COUNT);

    // Read-only counts and out-of-range control values are refused
    wire ro_hit = route_cnt_hit || capt_cnt_hit;
    wire known = sel_hit || ro_hit || ctrl_hit || cnt_wr || upos_wr
                 || spos_wr || irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_EVCNT)
                 || irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_UPOS)
                 || irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_SPOS);
    wire bad_wr = od_req.wr && (ro_hit || (ctrl_hit && !ctrl_ok));
    wire req_err = !known || bad_wr;

    wire [31:0] rd_val =
        route_cnt_hit ? {24'h000000, IRHC_ROUTE_CNT} :
        capt_cnt_hit ? {24'h000000, IRHC_CAPT_CNT} :
        sel_hit ? {24'h000000, sel_reg[sel_idx[5:0]]} :
        ctrl_hit ? {30'h00000000, mode_reg} :
        irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_EVCNT) ? evcnt_reg :
        irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_UPOS) ? upos_reg :
        irhc_hit(od_req, IRHC_IDX_CAPT, IRHC_SUB_SPOS) ? spos_reg :
        IRHC_W32_RST;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            od_rsp <= '0;
        end else begin
            od_rsp.ack <= od_req.rd | od_req.wr;
            od_rsp.err <= (od_req.rd | od_req.wr) & req_err;
            od_rsp.rdata <= od_req.rd ? rd_val : IRHC_W32_RST;
        end
    end

    // ------------------------------------------------------------
    // Routing selectors and routed word
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < N_ROUTE; i++)
                sel_reg[i] <= IRHC_SEL_RST;
        end else if (od_req.wr && sel_hit) begin
            sel_reg[sel_idx[5:0]] <= od_req.wdata[7:0];
        end
    end

    wire [N_ROUTE-1:0] route_next;
    genvar g;
    generate
        for (g = 0; g < N_ROUTE; g++) begin : g_route
            // With routing off, the raw inputs appear on the low bits
            if (g < IRHC_N_PHYS) begin : g_phys
                assign route_next[g] = routing_en ?
                    irhc_route_bit(sel_reg[g], sync2_reg) :
                    sync2_reg[g];
            end else begin : g_soft
                assign route_next[g] = routing_en &
                    irhc_route_bit(sel_reg[g], sync2_reg);
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (sys_rst)
            routed_input_word <= '0;
        else
            routed_input_word <= route_next;
    end

    // ------------------------------------------------------------
    // Home capture
    // ------------------------------------------------------------
    // A capture in the same cycle as a clear or write still counts
    wire [31:0] cnt_base = ctrl_clear ? IRHC_W32_RST :
                           cnt_wr ? od_req.wdata : evcnt_reg;
    wire [31:0] cnt_next = capture ? cnt_base + IRHC_CNT_ONE : cnt_base;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_reg <= IRHC_OFF;
            evcnt_reg <= IRHC_W32_RST;
            upos_reg <= IRHC_W32_RST;
            spos_reg <= IRHC_W32_RST;
        end else begin
            if (ctrl_wr)
                mode_reg <= irhc_mode_t'(od_req.wdata[1:0]);
            evcnt_reg <= cnt_next;
            upos_reg <= capture ? user_pos :
                        upos_wr ? od_req.wdata : upos_reg;
            spos_reg <= capture ? sensor_pos :
                        spos_wr ? od_req.wdata : spos_reg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sel_zero_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        routing_en && sel_reg[33] == IRHC_SEL_ZERO
        |=> !routed_input_word[33])
        else $error("zero selector did not give 0");
    sel_pass_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        routing_en && sel_reg[0] == {1'b0, IRHC_SEL_LO}
        |=> routed_input_word[0] == $past(sync2_reg[0]))
        else $error("selector 1 did not pass input 1");
    sel_one_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        routing_en && sel_reg[16] == IRHC_SEL_ONE
        |=> routed_input_word[16])
        else $error("one selector did not give 1");
    sel_inv_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        routing_en && sel_reg[17] == IRHC_SEL_INV1
        |=> routed_input_word[17] == !$past(sync2_reg[0]))
        else $error("inverted selector wrong");
    reset_vals_a: assert property (
        @(posedge mclk)
        sys_rst |=> sel_reg[5] == IRHC_SEL_RST && mode_reg == IRHC_OFF
        && routed_input_word == '0)
        else $error("reset values wrong");
    entry_count_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        od_req.rd && route_cnt_hit
        |=> od_rsp.ack && od_rsp.rdata == {24'h000000, IRHC_ROUTE_CNT})
        else $error("routing entry count wrong");
    route_off_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !routing_en |=> routed_input_word[N_ROUTE-1:IRHC_N_PHYS] == '0)
        else $error("routing active while disabled");
    mode_off_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (mode_reg == IRHC_OFF || !home_ena) && !ctrl_clear && !cnt_wr
        |=> evcnt_reg == $past(evcnt_reg))
        else $error("count moved while capture disabled");
    latch_pos_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        capture
        |=> upos_reg == $past(user_pos) && spos_reg == $past(sensor_pos))
        else $error("positions not latched");
    count_inc_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        capture && !ctrl_clear && !cnt_wr
        |=> evcnt_reg == $past(evcnt_reg) + IRHC_CNT_ONE)
        else $error("count not incremented");
    count_clr_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ctrl_clear && !capture |=> evcnt_reg == IRHC_W32_RST)
        else $error("count not cleared");
    rise_capt_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        mode_reg == IRHC_RISE && home_ena && $rose(home_now)
        |=> upos_reg == $past(user_pos))
        else $error("rising edge missed");
    sync_two_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !$past(sys_rst) && !$past(sys_rst, 2)
        |-> sync2_reg == $past(phys_in, 2))
        else $error("synchroniser depth wrong");

endmodule // irhc_core

// [rtl/irhc_pkg.sv]
// Constants, types and object-dictionary map of the input routing block
package irhc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int IRHC_N_PHYS = 16;
    localparam int IRHC_N_ROUTE = 36;
    localparam int IRHC_HOME_BIT = 2;
    localparam int IRHC_SEL_INV_BIT = 7;

    // ------------------------------------------------------------
    // Object-dictionary indices and subindices
    // ------------------------------------------------------------
    localparam logic [15:0] IRHC_IDX_ROUTE = 16'h3242;
    localparam logic [15:0] IRHC_IDX_CAPT = 16'h3243;
    localparam logic [7:0] IRHC_SUB_COUNT = 8'h00;
    localparam logic [7:0] IRHC_SUB_FIRST = 8'h01;
    localparam logic [7:0] IRHC_SUB_CTRL = 8'h01;
    localparam logic [7:0] IRHC_SUB_EVCNT = 8'h02;
    localparam logic [7:0] IRHC_SUB_UPOS = 8'h03;
    localparam logic [7:0] IRHC_SUB_SPOS = 8'h04;

    // ------------------------------------------------------------
    // Read-only entry counts and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] IRHC_ROUTE_CNT = 8'h24;
    localparam logic [7:0] IRHC_CAPT_CNT = 8'h04;
    localparam logic [7:0] IRHC_SEL_RST = 8'h00;
    localparam logic [31:0] IRHC_W32_RST = 32'h00000000;
    localparam logic [31:0] IRHC_CNT_ONE = 32'h00000001;
    localparam logic [31:0] IRHC_CTRL_MAX = 32'h00000003;

    // ------------------------------------------------------------
    // Selector codes
    // ------------------------------------------------------------
    localparam logic [7:0] IRHC_SEL_ZERO = 8'h00;
    localparam logic [7:0] IRHC_SEL_ONE = 8'h80;
    localparam logic [7:0] IRHC_SEL_INV1 = 8'h81;
    localparam logic [6:0] IRHC_SEL_LO = 7'h01;
    localparam logic [6:0] IRHC_SEL_HI = 7'h10;
    localparam logic [3:0] IRHC_SEL_BIAS = 4'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IRHC_OFF,
        IRHC_RISE,
        IRHC_FALL,
        IRHC_BOTH
    } irhc_mode_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } irhc_od_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } irhc_od_rsp_t;

endpackage

// [tb/irhc_field_model.sv]
// Far-side model: physical inputs, home switch and position encoder
module irhc_field_model (
    output logic [15:0] phys_in,
    output logic [31:0] user_pos,
    output logic [31:0] sensor_pos
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        phys_in = 16'h0000;
        user_pos = 32'h00000000;
        sensor_pos = 32'h00000000;
    end

    // Levels and positions move only on request, so a latched position is
    // known exactly; the bench moves the encoder again after each capture
    task automatic drive(input logic [15:0] p, input logic [31:0] u,
                         input logic [31:0] s);
        phys_in = p;
        user_pos = u;
        sensor_pos = s;
    endtask
endmodule // irhc_field_model

// [tb/irhc_core_tb.sv]
// Self-checking bench for the input routing and home capture block
module irhc_core_tb;
    import irhc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic routing_en = 1'b1;
    logic [31:0] special_fn_en = 32'h00000000;
    irhc_od_req_t od_req = '0;
    irhc_od_rsp_t od_rsp;
    logic [IRHC_N_PHYS-1:0] phys_in;
    logic [31:0] user_pos;
    logic [31:0] sensor_pos;
    logic [IRHC_N_ROUTE-1:0] routed_input_word;
    logic [15:0] pats [3] = '{16'ha5c3, 16'h5a3c, 16'hffff};
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    initial forever #12.5 mclk = ~mclk;

    irhc_field_model i_field (.phys_in(phys_in), .user_pos(user_pos),
                              .sensor_pos(sensor_pos));
    irhc_core i_dut (.mclk(mclk), .sys_rst(sys_rst), .phys_in(phys_in),
                     .routing_en(routing_en), .special_fn_en(special_fn_en),
                     .user_pos(user_pos), .sensor_pos(sensor_pos),
                     .od_req(od_req), .od_rsp(od_rsp),
                     .routed_input_word(routed_input_word));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One access; the answer stands in the cycle after the taking edge
    task automatic od(input logic wr, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] val,
                      input logic err_exp);
        od_req.wr = wr;
        od_req.rd = ~wr;
        od_req.index = idx;
        od_req.sub = sub;
        od_req.wdata = val;
        @(negedge mclk);
        od_req.wr = 1'b0;
        od_req.rd = 1'b0;
        check("ack", od_rsp.ack, 1'b1);
        check("err", od_rsp.err, err_exp);
        if (!wr && !err_exp) begin
            check("rdata", od_rsp.rdata, val);
        end
        @(negedge mclk);
    endtask

    // Every code class appears: 0, 1..16, 128, 129..144
    function automatic logic [7:0] sel_code(input int n);
        if (n <= 16) return n[7:0];
        if (n == 17) return 8'h80;
        if (n <= 33) return 8'h81 + 8'(n - 18);
        return (n == 35) ? 8'h10 : ((n == 36) ? 8'h90 : 8'h00);
    endfunction

    function automatic logic [35:0] route_exp(input logic [15:0] p);
        logic [7:0] c;
        route_exp = '0;
        for (int n = 1; n <= 36; n++) begin
            c = sel_code(n);
            if (c == 8'h80) route_exp[n-1] = 1'b1;
            else if (c >= 8'h81 && c <= 8'h90) route_exp[n-1] = ~p[c-8'h81];
            else if (c >= 8'h01 && c <= 8'h10) route_exp[n-1] = p[c-8'h01];
        end
    endfunction

    task automatic home(input logic lvl, input logic [31:0] u);
        i_field.drive({13'h0000, lvl, 2'h0}, u, u + 32'h00a00000);
        repeat (5) @(negedge mclk);
        i_field.drive({13'h0000, lvl, 2'h0}, ~u, u);
    endtask

    task automatic results;
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles > 5000) begin
            bad_count++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] pos;
        logic [31:0] spos;
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        check("routed", routed_input_word, 36'h0);
        od(1'b0, IRHC_IDX_ROUTE, 8'h00, 32'h24, 1'b0);
        od(1'b0, IRHC_IDX_CAPT, 8'h00, 32'h04, 1'b0);
        od(1'b0, IRHC_IDX_ROUTE, 8'h24, 32'h0, 1'b0);
        for (int s = 1; s <= 4; s++) begin
            od(1'b0, IRHC_IDX_CAPT, 8'(s), 32'h0, 1'b0);
        end
        od(1'b1, IRHC_IDX_ROUTE, 8'h00, 32'h55, 1'b1);
        od(1'b0, IRHC_IDX_ROUTE, 8'h00, 32'h24, 1'b0);
        od(1'b1, IRHC_IDX_CAPT, 8'h01, 32'h4, 1'b1);
        for (int n = 1; n <= 36; n++) begin
            od(1'b1, IRHC_IDX_ROUTE, 8'(n), 32'(sel_code(n)), 1'b0);
        end
        od(1'b0, IRHC_IDX_ROUTE, 8'h11, 32'h80, 1'b0);
        foreach (pats[i]) begin
            i_field.drive(pats[i], 32'h0, 32'h0);
            repeat (4) @(negedge mclk);
            check("routed", routed_input_word,
                  route_exp(pats[i]));
        end
        routing_en = 1'b0;
        repeat (2) @(negedge mclk);
        check("unrouted", routed_input_word, {20'h0, pats[2]});
        routing_en = 1'b1;
        special_fn_en = 32'h00000004;
        // Home is left high by the last pattern; bring it low with the
        // mode still off, so the first rising drive below is a real edge
        home(1'b0, 32'h0);
        od(1'b0, IRHC_IDX_CAPT, 8'h02, 32'h0, 1'b0);
        for (int m = 1; m <= 3; m++) begin
            // Rising-only mode keeps the rise position, the others the fall
            pos = (m == 1) ? 32'(16 * m + 1) : 32'(16 * m + 2);
            spos = pos + 32'h00a00000;
            od(1'b1, IRHC_IDX_CAPT, 8'h01, 32'(m), 1'b0);
            od(1'b0, IRHC_IDX_CAPT, 8'h02, 32'h0, 1'b0);
            home(1'b1, 32'(16 * m + 1));
            home(1'b0, 32'(16 * m + 2));
            od(1'b0, IRHC_IDX_CAPT, 8'h02, (m == 3) ? 2 : 1, 1'b0);
            od(1'b0, IRHC_IDX_CAPT, 8'h03, pos, 1'b0);
            od(1'b0, IRHC_IDX_CAPT, 8'h04, spos, 1'b0);
        end
        od(1'b1, IRHC_IDX_CAPT, 8'h01, 32'h0, 1'b0);
        home(1'b1, 32'h77);
        od(1'b0, IRHC_IDX_CAPT, 8'h02, 32'h2, 1'b0);
        od(1'b1, IRHC_IDX_CAPT, 8'h01, 32'h3, 1'b0);
        special_fn_en = 32'h00000000;
        home(1'b0, 32'h78);
        od(1'b0, IRHC_IDX_CAPT, 8'h02, 32'h0, 1'b0);
        od(1'b0, IRHC_IDX_CAPT, 8'h03, 32'h32, 1'b0);
        od(1'b1, IRHC_IDX_CAPT, 8'h02, 32'h5, 1'b0);
        od(1'b0, IRHC_IDX_CAPT, 8'h02, 32'h5, 1'b0);
        // Reset in mid-run with every selector and counter loaded
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        check("routed", routed_input_word, 36'h0);
        od(1'b0, IRHC_IDX_ROUTE, 8'h11, 32'h0, 1'b0);
        od(1'b0, IRHC_IDX_CAPT, 8'h01, 32'h0, 1'b0);
        od(1'b0, IRHC_IDX_CAPT, 8'h02, 32'h0, 1'b0);
        results();
    end
endmodule // irhc_core_tb
